// ---- dv/trpa_pins.sv ----
// trpa_pins: port A pins outside the timer, resolving drivers.
// assumes the bench supplies the level of undriven pins.
module trpa_pins
(
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] ext_drive,
  output logic [7:0] port_a_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven pin reads back its own level, bit 7 included
  assign port_a_in = (port_a_oe & port_a_out)
                   | (~port_a_oe & ext_drive);
endmodule : trpa_pins

// ---- dv/trpa_timer_chk.sv ----
// trpa_timer_chk: port-level assertions on the timer block.
// assumes one clock and a synchronous active-high reset.
module trpa_timer_chk
  import trpa_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] prescale_main_sel,
  input wire logic aux_counter_write,
  input wire logic cmp_wr_hi,
  input wire logic cmp_wr_lo,
  input wire logic accum_wr,
  input wire logic [15:0] main_free_counter,
  input wire logic [15:0] aux_free_counter,
  input wire logic [15:0] fixed_compare_regs [4],
  input wire logic [9:0] channel_flags,
  input wire logic [9:0] channel_irq,
  input wire logic [9:0] channel_irq_enables,
  input wire logic [4:0] misc_flags,
  input wire logic [4:0] misc_irq,
  input wire logic [4:0] misc_irq_enables,
  input wire logic [7:0] accum_count_reg,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_a_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // counter and storage behaviour
  AST_AUX_CLEAR: assert property (aux_counter_write |=>
    aux_free_counter == 16'h0000) else $error("aux counter not cleared");
  AST_MAIN_STEP: assert property (prescale_main_sel == 2'h0 ##1
    prescale_main_sel == 2'h0 |->
    main_free_counter == $past(main_free_counter) + 16'h0001)
    else $error("main counter not stepping at full rate");
  AST_CMP_RESET: assert property ($fell(rst) |->
    fixed_compare_regs[0] == 16'hFFFF && fixed_compare_regs[3] == 16'hFFFF)
    else $error("compare register not all ones after reset");
  AST_CMP_HOLD: assert property (!cmp_wr_hi && !cmp_wr_lo |=>
    $stable(fixed_compare_regs[1])) else $error("compare changed unwritten");
  // request outputs follow flags gated by enables
  AST_CHAN_IRQ: assert property (channel_irq ==
    (channel_flags & channel_irq_enables)) else $error("channel request");
  AST_MISC_IRQ: assert property (misc_irq ==
    (misc_flags & misc_irq_enables)) else $error("misc request wrong");
  // wrap by counting, not by a software write, must raise the flag
  AST_ACC_WRAP: assert property (
    accum_count_reg == 8'hFF && !accum_wr ##1
    accum_count_reg == 8'h00 |-> ##[0:1] misc_flags[MF_ACC_OVF])
    else $error("accumulator wrap without flag");
  AST_PIN_READ: assert property (
    port_a_state == ((port_a_oe & port_a_out)
    | (~port_a_oe & port_a_in))) else $error("pin readback wrong");
endmodule : trpa_timer_chk

bind trpa_timer trpa_timer_chk chk_u (.*);

// ---- dv/trpa_timer_tb.sv ----
// trpa_timer_tb: directed self-checking bench for the timer block.
// assumes the pin model trpa_pins and the bound checker.
module trpa_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import trpa_pkg::*;
  logic clock = 0, rst = 1, ext_clk_pin = 0, aux_counter_write = 0;
  logic main_cnt_hi_read = 0, aux_cnt_hi_read = 0, force_compare_wr = 0;
  logic chan_five_dir_sel = 0, chan_six_dir_sel = 0, chan_seven_dir_sel = 0;
  logic cmp_wr_hi = 0, cmp_wr_lo = 0, accum_enable_bit = 0, accum_wr = 0;
  logic accum_mode_bit = 0, accum_edge_select = 0;
  logic [1:0] prog_pin_in = '0, prescale_main_sel = '0, prescale_aux_sel = '0;
  logic [1:0] ext_edge_sel = '0, prog_pin_out, prog_pin_oe;
  logic [2:0] cmp_wr_sel = '0, periodic_rate_field = '0;
  logic [4:0] master_compare_mask = '0, master_compare_levels = '0;
  logic [4:0] misc_irq_enables = '0, misc_flag_clear = '0;
  logic [4:0] misc_flags, misc_irq;
  logic [6:0] force_compare_reg = '0;
  logic [7:0] port_direction_reg = '0, cmp_wr_data = '0, accum_wr_data = '0;
  logic [7:0] ext_drive = '0, port_a_in, port_a_out, port_a_oe, port_a_state;
  logic [7:0] main_cnt_lo_byte, aux_cnt_lo_byte, accum_count_reg;
  logic [9:0] channel_irq_enables = '0, channel_flag_clear = '0;
  logic [9:0] channel_flags, channel_irq;
  logic [11:0] capture_edge_ctl = '0, compare_action_ctl = '0;
  logic [15:0] main_free_counter, aux_free_counter, prog_channel_five_reg;
  logic [15:0] prog_channel_six_reg, prog_channel_seven_reg, c;
  logic [15:0] fixed_capture_regs [3];
  logic [15:0] fixed_compare_regs [4];
  int errors = 0, checks_done = 0;

  // short periodic base keeps the first timeout at 16 cycles
  trpa_timer #(.RTI_BASE_LOG2(4)) dut_u (.*);
  trpa_pins pins_u (.*);

  always #10 clock = ~clock;

  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // high byte first, low byte on the next cycle, as the inhibit expects
  task wr_cmp(input logic [2:0] sel, input logic [15:0] v);
    cmp_wr_sel = sel;
    cmp_wr_hi = 1;
    cmp_wr_data = v[15:8];
    cyc(1);
    cmp_wr_hi = 0;
    cmp_wr_lo = 1;
    cmp_wr_data = v[7:0];
    cyc(1);
    cmp_wr_lo = 0;
  endtask : wr_cmp

  task end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task t_reset;
    for (int i = 0; i < 4; i++) chk(fixed_compare_regs[i], CMP_RESET);
    chk(misc_flags, 16'h0000);
    cyc(12);
    chk(misc_flags[MF_PERIODIC], 16'h0000);
    cyc(8);
    chk(misc_flags[MF_PERIODIC], 16'h0001);
    $display("test reset done");
  endtask : t_reset

  task t_prescale;
    for (int s = 0; s < 4; s++) begin
      prescale_main_sel = s[1:0];
      cyc(16);
      c = main_free_counter;
      cyc(16);
      chk(main_free_counter - c, 16'h0010 >> s);
    end
    aux_counter_write = 1;
    cyc(1);
    aux_counter_write = 0;
    chk(aux_free_counter, 16'h0000);
    $display("test prescale done");
  endtask : t_prescale

  // rise then fall on the three fixed capture pins for every edge code
  task t_capture;
    for (int k = 0; k < 4; k++) begin
      capture_edge_ctl[5:0] = {3{k[1:0]}};
      c = aux_free_counter;
      ext_drive[2:0] = 3'h7;
      cyc(5);
      chk(channel_flags[2:0], {3{k[0]}});
      if (k == 1) chk(fixed_capture_regs[0] - c, 16'h0002);
      ext_drive[2:0] = 3'h0;
      cyc(5);
      chk(channel_flags[2:0], (k != 0) ? 16'h0007 : 16'h0000);
      channel_flag_clear = 10'h3FF;
      cyc(1);
      channel_flag_clear = 10'h000;
    end
    $display("test capture done");
  endtask : t_capture

  // slow prescale keeps each match true for eight cycles
  task t_compare;
    prescale_main_sel = 2'h3;
    channel_irq_enables[4] = 1;
    compare_action_ctl[1:0] = ACT_SET;
    wr_cmp(3'h1, main_free_counter + 16'h0010);
    cyc(150);
    chk(port_a_out[6], 16'h0001);
    chk(channel_irq[4], 16'h0001);
    compare_action_ctl[1:0] = ACT_TOGGLE;
    wr_cmp(3'h1, main_free_counter + 16'h0008);
    cyc(90);
    chk(port_a_out[6], 16'h0000);
    compare_action_ctl[1:0] = ACT_OFF;
    master_compare_mask = 5'h08;
    master_compare_levels = 5'h08;
    wr_cmp(3'h0, main_free_counter + 16'h0008);
    cyc(90);
    chk(port_a_out[6], 16'h0001);
    master_compare_mask = 5'h00;
    compare_action_ctl[3:2] = ACT_TOGGLE;
    c[0] = port_a_out[5];
    force_compare_reg = 7'h04;
    force_compare_wr = 1;
    cyc(1);
    force_compare_wr = 0;
    cyc(1);
    chk(port_a_out[5], {15'h0000, ~c[0]});
    $display("test compare done");
  endtask : t_compare

  task t_accum;
    accum_enable_bit = 1;
    accum_edge_select = 1;
    misc_irq_enables = 5'h18;
    accum_wr_data = ACC_WRAP;
    accum_wr = 1;
    cyc(1);
    accum_wr = 0;
    ext_drive[7] = 1;
    cyc(5);
    chk(accum_count_reg, 16'h0000);
    chk(misc_irq[4:3], 16'h0003);
    accum_mode_bit = 1;
    cyc(130);
    chk(accum_count_reg, 16'h0000);
    ext_drive[7] = 0;
    cyc(130);
    chk(accum_count_reg inside {8'h02, 8'h03}, 16'h0001);
    $display("test accum done");
  endtask : t_accum

  // held low byte, external clock on aux, capture on channel five
  task t_misc;
    c = aux_free_counter;
    aux_cnt_hi_read = 1;
    cyc(1);
    aux_cnt_hi_read = 0;
    chk(aux_cnt_lo_byte, c & 16'h00FF);
    cyc(1);
    chk(aux_cnt_lo_byte, (c + 16'h0002) & 16'h00FF);
    prescale_main_sel = 2'h0;
    chan_five_dir_sel = 1;
    capture_edge_ctl[7:6] = EDGE_RISE;
    c = main_free_counter;
    ext_drive[3] = 1;
    ext_edge_sel = EDGE_RISE;
    aux_counter_write = 1;
    cyc(1);
    aux_counter_write = 0;
    // slow external pulses, well under the synchroniser's limit
    repeat (3) begin
      ext_clk_pin = 1;
      cyc(2);
      ext_clk_pin = 0;
      cyc(2);
    end
    chk(prog_channel_five_reg - c, 16'h0002);
    chk(channel_flags[FLG_PROG5], 16'h0001);
    cyc(2);
    chk(aux_free_counter, 16'h0003);
    $display("test misc done");
  endtask : t_misc

  initial begin
    cyc(12);
    rst = 0;
    t_reset;
    t_prescale;
    t_capture;
    t_compare;
    t_accum;
    t_misc;
    end_sim;
  end

  // cut a hang well past the expected run of about 830 cycles
  initial begin
    #80000;
    errors++;
    end_sim;
  end
endmodule : trpa_timer_tb

// ---- rtl/trpa_pkg.sv ----
// trpa_pkg: constants shared by the timer, periodic tick and accumulator.
// assumes one clock (the E-clock) and a synchronous active-high reset.
package trpa_pkg;
  // counter and register widths
  localparam int CNT_W = 16;
  localparam int ACC_W = 8;
  localparam int PRE_W = 3;
  localparam int RTI_CNT_W = 24;
  localparam int GATE_DIV_W = 6;
  // values after reset and at wrap
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_WRAP = 16'hFFFF;
  localparam logic [15:0] CMP_RESET = 16'hFFFF;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] ACC_WRAP = 8'hFF;
  localparam logic [1:0] PRE_RESET = 2'h0;
  // gated accumulation runs from E/64
  localparam logic [5:0] GATE_TICK_AT = 6'h3F;
  // default log2 of the shortest periodic timeout, in E-clock cycles
  localparam int RTI_BASE_LOG2_DEF = 13;
  // two-bit edge select encoding (capture, external clock)
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // two-bit compare action encoding
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // channel flag positions: fixed captures, fixed compares, programmables
  localparam int FLG_CAP1 = 0;
  localparam int FLG_OC1 = 3;
  localparam int FLG_PROG5 = 7;
  localparam int NUM_CHAN = 10;
  // misc flag positions
  localparam int MF_MAIN_OVF = 0;
  localparam int MF_AUX_OVF = 1;
  localparam int MF_PERIODIC = 2;
  localparam int MF_ACC_OVF = 3;
  localparam int MF_ACC_IN = 4;
  localparam int NUM_MISC = 5;
  // port A bit positions
  localparam int PA_CAP1 = 2;
  localparam int PA_CAP2 = 1;
  localparam int PA_CAP3 = 0;
  localparam int PA_OC1 = 7;
  localparam int PA_PROG5 = 3;
  localparam int PA_MASTER_LO = 3;
  localparam int PA_ACC = 7;
endpackage : trpa_pkg

// ---- rtl/trpa_sync_edge.sv ----
// trpa_sync_edge: two-stage synchroniser plus edge detector for one pin.
// assumes the pin may change at any time relative to the clock.
module trpa_sync_edge
  import trpa_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  output logic level,
  output logic hit
);
  logic meta;
  logic prev;
  logic rise;
  logic fall;

  // meta feeds only the second stage; edges look at level and prev
  always_ff @(posedge clock) begin
    if (rst) begin
      meta <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      level <= meta;
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

  // selected transition, none when disabled
  always_comb begin
    case (edge_sel)
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end
endmodule : trpa_sync_edge

// ---- rtl/trpa_timer.sv ----
// trpa_timer: two counters, captures, compares, periodic tick, accumulator.
// assumes software strobes arrive as one-cycle pulses on the E-clock.
// Function
// - two 16-bit counters, each with own 1/2/4/8 prescaler
// - any write clears aux counter; main counter ignores writes
// - after reset both counters count at undivided E rate
// - only aux counter takes external clock edges; prescaler then ignored
// - fixed captures 16-bit, read-only, not reset, latch counter on edge
// - two-bit edge field: rising, falling, both or no capture
// - fixed captures take port A bits 2, 1, 0
// - compare registers reset to all ones, never changed by hardware
// - compares one to four drive port A bits 7 to 4; pins readable
// - two-bit action: toggle, set, clear or disconnect on match
// - compare one drives bits 3 to 7 through mask and levels
// - force register write performs compare output action at once
// - output action only once, just after match first becomes true
// - compare sets flag; interrupt request when enable set
// - high-byte write suppresses comparison for one cycle
// - byte writes independent; action regardless of flag state
// - three programmable channels choose capture or compare per bit
// - three-bit rate picks periodic timeout; sets flag, gated request
// - first periodic flag only after a whole period from reset
// - 8-bit accumulator, event mode or gated E/64 mode
// - port A bit 7 always feeds accumulator; enable and edge bits
// - accumulator overflow and input flags, each with own mask
// - counters wrap at 65536 and set overflow flag with enable
// - captured value is counter two cycles after the transition
// - high-byte read holds low byte for the next cycle
module trpa_timer
  import trpa_pkg::*;
#(
  parameter int RTI_BASE_LOG2 = RTI_BASE_LOG2_DEF
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_a_state,
  input wire logic [7:0] port_direction_reg,
  input wire logic [1:0] prog_pin_in,
  output logic [1:0] prog_pin_out,
  output logic [1:0] prog_pin_oe,
  input wire logic ext_clk_pin,
  input wire logic [1:0] prescale_main_sel,
  input wire logic [1:0] prescale_aux_sel,
  input wire logic [1:0] ext_edge_sel,
  input wire logic aux_counter_write,
  input wire logic main_cnt_hi_read,
  input wire logic aux_cnt_hi_read,
  output logic [15:0] main_free_counter,
  output logic [15:0] aux_free_counter,
  output logic [7:0] main_cnt_lo_byte,
  output logic [7:0] aux_cnt_lo_byte,
  input wire logic [11:0] capture_edge_ctl,
  input wire logic [11:0] compare_action_ctl,
  input wire logic chan_five_dir_sel,
  input wire logic chan_six_dir_sel,
  input wire logic chan_seven_dir_sel,
  input wire logic [4:0] master_compare_mask,
  input wire logic [4:0] master_compare_levels,
  input wire logic force_compare_wr,
  input wire logic [6:0] force_compare_reg,
  input wire logic cmp_wr_hi,
  input wire logic cmp_wr_lo,
  input wire logic [2:0] cmp_wr_sel,
  input wire logic [7:0] cmp_wr_data,
  output logic [15:0] fixed_capture_regs [3],
  output logic [15:0] fixed_compare_regs [4],
  output logic [15:0] prog_channel_five_reg,
  output logic [15:0] prog_channel_six_reg,
  output logic [15:0] prog_channel_seven_reg,
  input wire logic [9:0] channel_irq_enables,
  input wire logic [9:0] channel_flag_clear,
  output logic [9:0] channel_flags,
  output logic [9:0] channel_irq,
  input wire logic [4:0] misc_irq_enables,
  input wire logic [4:0] misc_flag_clear,
  output logic [4:0] misc_flags,
  output logic [4:0] misc_irq,
  input wire logic [2:0] periodic_rate_field,
  input wire logic accum_enable_bit,
  input wire logic accum_mode_bit,
  input wire logic accum_edge_select,
  input wire logic accum_wr,
  input wire logic [7:0] accum_wr_data,
  output logic [7:0] accum_count_reg
);
  // prescale tap: sel 0 every cycle, else when the lowest sel bits of div are all ones
  function automatic logic tap_tick(input logic [2:0] div,
                                    input logic [1:0] sel);
    case (sel)
      2'h0: tap_tick = 1'b1;
      2'h1: tap_tick = div[0];
      2'h2: tap_tick = &div[1:0];
      2'h3: tap_tick = &div[2:0];
      default: tap_tick = 1'b1;
    endcase
  endfunction : tap_tick

  // new pin level for one compare action
  function automatic logic pin_action(input logic cur,
                                      input logic [1:0] code);
    case (code)
      ACT_TOGGLE: pin_action = ~cur;
      ACT_CLEAR: pin_action = 1'b0;
      ACT_SET: pin_action = 1'b1;
      default: pin_action = cur;
    endcase
  endfunction : pin_action

  // low byte: held copy only in the cycle after a high-byte read
  function automatic logic [7:0] low_read(input logic hold,
                                          input logic [7:0] held,
                                          input logic [15:0] cnt);
    low_read = hold ? held : cnt[7:0];
  endfunction : low_read

  logic [2:0] main_div;
  logic [2:0] aux_div;
  logic main_tick;
  logic aux_tick;
  logic main_wrap;
  logic aux_wrap;
  logic main_hold;
  logic aux_hold;
  logic [7:0] main_held;
  logic [7:0] aux_held;
  logic [7:0] sync_pin;
  logic [15:0] sync_sel;
  logic [7:0] sync_level;
  logic [7:0] sync_hit;
  logic [2:0] cap_mode;
  logic [15:0] cmp_reg [7];
  logic [6:0] cmp_inhibit;
  logic [6:0] match_now;
  logic [6:0] match_prev;
  logic [6:0] cmp_hit;
  logic [6:0] act_pend;
  logic [7:0] pa_latch;
  logic [7:0] next_pa;
  logic [1:0] prog_latch;
  logic [1:0] next_prog;
  logic [7:0] pa_owned;
  logic [9:0] next_chan_set;
  logic [4:0] next_misc_set;
  logic [RTI_CNT_W-1:0] rti_cnt;
  logic [RTI_CNT_W-1:0] rti_mask;
  logic rti_timeout;
  logic [5:0] gate_div;
  logic acc_edge;
  logic acc_inc;

  assign cap_mode = {chan_seven_dir_sel, chan_six_dir_sel, chan_five_dir_sel};

  // inputs that pass through synchronisers, with their edge selects
  assign sync_pin = {ext_clk_pin, port_a_in[PA_ACC], prog_pin_in,
                     port_a_in[PA_PROG5], port_a_in[PA_CAP3],
                     port_a_in[PA_CAP2], port_a_in[PA_CAP1]};
  assign acc_edge = accum_edge_select;
  assign sync_sel = {ext_edge_sel, (acc_edge ? EDGE_RISE : EDGE_FALL),
                     capture_edge_ctl};

  for (genvar g = 0; g < 8; g++) begin : g_sync
    trpa_sync_edge u_sync (
      .clock(clock),
      .rst(rst),
      .pin(sync_pin[g]),
      .edge_sel(sync_sel[2*g+1:2*g]),
      .level(sync_level[g]),
      .hit(sync_hit[g])
    );
  end

  // prescaler chains free-run from reset; taps pick the counting rate
  always_ff @(posedge clock) begin
    if (rst) begin
      main_div <= 3'h0;
      aux_div <= 3'h0;
    end else begin
      main_div <= main_div + 3'h1;
      aux_div <= aux_div + 3'h1;
    end
  end

  // reset leaves the selects at divide by one until software changes them
  assign main_tick = tap_tick(main_div, prescale_main_sel);
  assign aux_tick = (ext_edge_sel != EDGE_NONE) ? sync_hit[7]
                  : tap_tick(aux_div, prescale_aux_sel);
  assign main_wrap = main_tick & (main_free_counter == CNT_WRAP);
  assign aux_wrap = aux_tick & (aux_free_counter == CNT_WRAP)
                  & ~aux_counter_write;

  // main counter: writes are simply not wired to it
  always_ff @(posedge clock) begin
    if (rst) begin
      main_free_counter <= CNT_RESET;
    end else if (main_tick) begin
      main_free_counter <= main_free_counter + 16'h0001;
    end
  end

  // aux counter: a write of any value clears it, ahead of counting
  always_ff @(posedge clock) begin
    if (rst) begin
      aux_free_counter <= CNT_RESET;
    end else if (aux_counter_write) begin
      aux_free_counter <= CNT_RESET;
    end else if (aux_tick) begin
      aux_free_counter <= aux_free_counter + 16'h0001;
    end
  end

  // low-byte holding buffers for coherent double-byte reads
  always_ff @(posedge clock) begin
    if (rst) begin
      main_hold <= 1'b0;
      aux_hold <= 1'b0;
    end else begin
      main_hold <= main_cnt_hi_read;
      aux_hold <= aux_cnt_hi_read;
    end
  end

  // buffer content itself needs no reset; it is read only while held
  always_ff @(posedge clock) begin
    if (main_cnt_hi_read) begin
      main_held <= main_free_counter[7:0];
    end
    if (aux_cnt_hi_read) begin
      aux_held <= aux_free_counter[7:0];
    end
  end

  assign main_cnt_lo_byte = low_read(main_hold, main_held, main_free_counter);
  assign aux_cnt_lo_byte = low_read(aux_hold, aux_held, aux_free_counter);

  // fixed captures: no reset, aux counter; synchroniser gives the lag
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (sync_hit[i]) begin
        fixed_capture_regs[i] <= aux_free_counter;
      end
    end
  end

  // compare registers plus the programmable channels' capture path
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int k = 0; k < 7; k++) begin
        cmp_reg[k] <= CMP_RESET;
      end
    end else begin
      if (cmp_wr_hi && cmp_wr_sel < 3'h7) begin
        cmp_reg[cmp_wr_sel][15:8] <= cmp_wr_data;
      end
      if (cmp_wr_lo && cmp_wr_sel < 3'h7) begin
        cmp_reg[cmp_wr_sel][7:0] <= cmp_wr_data;
      end
      // channels five and six count main, seven counts aux
      if (cap_mode[0] && sync_hit[3]) begin
        cmp_reg[4] <= main_free_counter;
      end
      if (cap_mode[1] && sync_hit[4]) begin
        cmp_reg[5] <= main_free_counter;
      end
      if (cap_mode[2] && sync_hit[5]) begin
        cmp_reg[6] <= aux_free_counter;
      end
    end
  end

  assign fixed_compare_regs[0] = cmp_reg[0];
  assign fixed_compare_regs[1] = cmp_reg[1];
  assign fixed_compare_regs[2] = cmp_reg[2];
  assign fixed_compare_regs[3] = cmp_reg[3];
  assign prog_channel_five_reg = cmp_reg[4];
  assign prog_channel_six_reg = cmp_reg[5];
  assign prog_channel_seven_reg = cmp_reg[6];

  // match detect; a high-byte write blanks that channel for one cycle
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      match_now[k] = ~cmp_inhibit[k]
                   & (cmp_reg[k] == ((k == 6) ? aux_free_counter
                                              : main_free_counter));
      if (k >= 4) begin
        match_now[k] = match_now[k] & ~cap_mode[k-4];
      end
    end
  end

  // only the first cycle of a match counts; a prescaled count lingers
  assign cmp_hit = match_now & ~match_prev;

  always_ff @(posedge clock) begin
    if (rst) begin
      cmp_inhibit <= 7'h00;
      match_prev <= 7'h00;
      act_pend <= 7'h00;
    end else begin
      cmp_inhibit <= (cmp_wr_hi && cmp_wr_sel < 3'h7)
                   ? 7'(7'h01 << cmp_wr_sel) : 7'h00;
      match_prev <= match_now;
      // action lands the cycle after, flag state not consulted
      act_pend <= cmp_hit
                | (force_compare_wr ? force_compare_reg : 7'h00);
    end
  end

  // pin levels: master compare first, own channels override it
  always_comb begin
    next_pa = pa_latch;
    next_prog = prog_latch;
    if (act_pend[0]) begin
      for (int i = 0; i < 5; i++) begin
        if (master_compare_mask[i]) begin
          next_pa[PA_MASTER_LO+i] = master_compare_levels[i];
        end
      end
    end
    for (int k = 1; k < 4; k++) begin
      if (act_pend[k]) begin
        next_pa[PA_OC1-k] = pin_action(pa_latch[PA_OC1-k],
                                       compare_action_ctl[2*k-1 -: 2]);
      end
    end
    if (act_pend[4] && !cap_mode[0]) begin
      next_pa[PA_PROG5] = pin_action(pa_latch[PA_PROG5],
                                     compare_action_ctl[7:6]);
    end
    for (int p = 0; p < 2; p++) begin
      if (act_pend[5+p] && !cap_mode[1+p]) begin
        next_prog[p] = pin_action(prog_latch[p],
                                  compare_action_ctl[2*p+9 -: 2]);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pa_latch <= 8'h00;
      prog_latch <= 2'h0;
    end else begin
      pa_latch <= next_pa;
      prog_latch <= next_prog;
    end
  end

  // a pin belongs to the timer while a channel is connected to it, bit 3 only while channel five is not capturing
  always_comb begin
    pa_owned = 8'h00;
    for (int i = 0; i < 5; i++) begin
      pa_owned[PA_MASTER_LO+i] = master_compare_mask[i];
    end
    for (int k = 1; k < 4; k++) begin
      pa_owned[PA_OC1-k] = pa_owned[PA_OC1-k]
                         | (compare_action_ctl[2*k-1 -: 2] != ACT_OFF);
    end
    pa_owned[PA_PROG5] = ~cap_mode[0]
                       & (pa_owned[PA_PROG5]
                          | (compare_action_ctl[7:6] != ACT_OFF));
  end

  assign port_a_out = pa_latch;
  assign port_a_oe = port_direction_reg | pa_owned;
  // readback shows what the pin really carries
  assign port_a_state = (port_a_oe & pa_latch)
                      | (~port_a_oe & port_a_in);
  assign prog_pin_out = prog_latch;
  assign prog_pin_oe[0] = ~cap_mode[1] & (compare_action_ctl[9:8] != ACT_OFF);
  assign prog_pin_oe[1] = ~cap_mode[2]
                        & (compare_action_ctl[11:10] != ACT_OFF);

  // channel flag sources; force writes do not raise flags
  always_comb begin
    next_chan_set = 10'h000;
    for (int i = 0; i < 3; i++) begin
      next_chan_set[FLG_CAP1+i] = sync_hit[i];
    end
    for (int k = 0; k < 4; k++) begin
      next_chan_set[FLG_OC1+k] = cmp_hit[k];
    end
    for (int p = 0; p < 3; p++) begin
      next_chan_set[FLG_PROG5+p] = cap_mode[p] ? sync_hit[3+p]
                                               : cmp_hit[4+p];
    end
  end

  // periodic timer: a free E-cycle count, timeout at 2^(base+rate)
  assign rti_mask = RTI_CNT_W'((32'd1 << (RTI_BASE_LOG2
                    + int'(periodic_rate_field))) - 32'd1);
  assign rti_timeout = (rti_cnt & rti_mask) == rti_mask;

  always_ff @(posedge clock) begin
    if (rst) begin
      rti_cnt <= '0;
    end else begin
      rti_cnt <= rti_cnt + RTI_CNT_W'(1);
    end
  end

  // accumulator: E/64 gate clock and input path from port A bit 7
  always_ff @(posedge clock) begin
    if (rst) begin
      gate_div <= 6'h00;
    end else begin
      gate_div <= gate_div + 6'h01;
    end
  end

  // gated mode counts while the pin sits opposite its ending edge
  assign acc_inc = accum_enable_bit & ~accum_wr
                 & (accum_mode_bit
                    ? ((gate_div == GATE_TICK_AT)
                       & (sync_level[6] == ~acc_edge))
                    : sync_hit[6]);

  always_ff @(posedge clock) begin
    if (rst) begin
      accum_count_reg <= ACC_RESET;
    end else if (accum_wr) begin
      accum_count_reg <= accum_wr_data;
    end else if (acc_inc) begin
      accum_count_reg <= accum_count_reg + 8'h01;
    end
  end

  always_comb begin
    next_misc_set = 5'h00;
    next_misc_set[MF_MAIN_OVF] = main_wrap;
    next_misc_set[MF_AUX_OVF] = aux_wrap;
    next_misc_set[MF_PERIODIC] = rti_timeout;
    next_misc_set[MF_ACC_OVF] = acc_inc
                              & (accum_count_reg == ACC_WRAP);
    next_misc_set[MF_ACC_IN] = accum_enable_bit & sync_hit[6];
  end

  // sticky flags: an event in the clearing cycle wins over the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      channel_flags <= 10'h000;
      misc_flags <= 5'h00;
    end else begin
      channel_flags <= (channel_flags & ~channel_flag_clear) | next_chan_set;
      misc_flags <= (misc_flags & ~misc_flag_clear) | next_misc_set;
    end
  end

  // requests follow flags, each gated by its own enable
  assign channel_irq = channel_flags & channel_irq_enables;
  assign misc_irq = misc_flags & misc_irq_enables;
endmodule : trpa_timer
